/* lcs_byte_if.sv */
`timescale 1ns/100ps

interface lcs_byte_if;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] q;

    modport owner (input we, input wdata, output q);
    modport user  (output we, output wdata, input q);
    modport watch (input q);
endinterface : lcs_byte_if

/* lcs_byte_reg.sv */
`timescale 1ns/100ps
`include "lcs_defines.svh"

module lcs_byte_reg (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   ce,
    lcs_byte_if.owner   bus
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // ****************************************************************
    // Storage, all eight bits kept so spare bits read back
    // ****************************************************************
    always_comb begin
        q_nxt = q_r;
        if (bus.we) begin
            q_nxt = bus.wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= `LCS_BYTE_RST;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    assign bus.q = q_r;
endmodule : lcs_byte_reg

/* lcs_code_join.sv */
`timescale 1ns/100ps
`include "lcs_defines.svh"

module lcs_code_join (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    ce,
    lcs_byte_if.watch                    high,
    lcs_byte_if.watch                    low,
    output logic [`LCS_CODE_W-1:0]       code,
    output logic                         request,
    output logic [`LCS_NOM_W-1:0]        nominal_10ua
);
    logic [`LCS_CODE_W-1:0] code_r;
    logic [`LCS_CODE_W-1:0] code_nxt;
    logic                   request_r;
    logic                   request_nxt;
    logic [`LCS_NOM_W-1:0]  nominal_r;
    logic [`LCS_NOM_W-1:0]  nominal_nxt;

    // ****************************************************************
    // Setpoint forming
    // ****************************************************************
    always_comb begin
        code_nxt    = {high.q[`LCS_HIGH_MSB:0], low.q};
        request_nxt = (code_nxt != `LCS_CODE_RST);
        // Full code range kept, no clip; product fits 18 bits
        nominal_nxt = `LCS_NOM_W'(code_nxt) * `LCS_STEP_10UA;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_r    <= `LCS_CODE_RST;
            request_r <= 1'b0;
            nominal_r <= `LCS_NOM_RST;
        end else if (ce) begin
            code_r    <= code_nxt;
            request_r <= request_nxt;
            nominal_r <= nominal_nxt;
        end
    end

    assign code         = code_r;
    assign request      = request_r;
    assign nominal_10ua = nominal_r;
endmodule : lcs_code_join

/* lcs_defines.svh */
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define LCS_IDX_CH2_HIGH   6'h05
`define LCS_IDX_CH2_LOW    6'h06
`define LCS_IDX_CH3_HIGH   6'h07
`define LCS_IDX_CH3_LOW    6'h08
`define LCS_IDX_STATUS     6'h10

// ****************************************************************
// Bus geometry and field layout
// ****************************************************************
`define LCS_ADDR_W         8
`define LCS_IDX_MSB        7
`define LCS_IDX_LSB        2
`define LCS_NUM_REGS       4
`define LCS_SEL_CH2_HIGH   0
`define LCS_SEL_CH2_LOW    1
`define LCS_SEL_CH3_HIGH   2
`define LCS_SEL_CH3_LOW    3
`define LCS_BYTE_RST       8'h00
`define LCS_CODE_W         10
`define LCS_CODE_RST       10'h000
`define LCS_STAT_CH3_LSB   16
`define LCS_HIGH_MSB       1
`define LCS_NOM_W          18
`define LCS_NOM_RST        18'h00000
`define LCS_STEP_10UA      18'h000f7
`define LCS_RESP_OKAY      2'h0
`define LCS_RESP_SLVERR    2'h2
`define LCS_WORD_RST       32'h00000000

`endif

/* lcs_pkg.sv */
package lcs_pkg;

    // ****************************************************************
    // Channel state machines, one-hot
    // ****************************************************************
    typedef enum logic [1:0] {
        LCS_WR_IDLE = 2'b01,
        LCS_WR_RESP = 2'b10
    } lcs_wr_state_type;

    typedef enum logic [1:0] {
        LCS_RD_IDLE = 2'b01,
        LCS_RD_DATA = 2'b10
    } lcs_rd_state_type;

endpackage : lcs_pkg

/* lcs_setpoint_regs.sv */
`timescale 1ns/100ps
`include "lcs_defines.svh"

module lcs_setpoint_regs (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    ce,
    input  wire logic [`LCS_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`LCS_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [`LCS_CODE_W-1:0]       ch2_current_code,
    output logic                         ch2_current_request,
    output logic [`LCS_NOM_W-1:0]        ch2_current_nominal_10ua,
    output logic [`LCS_CODE_W-1:0]       ch3_current_code,
    output logic                         ch3_current_request,
    output logic [`LCS_NOM_W-1:0]        ch3_current_nominal_10ua
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int IDX_W = `LCS_IDX_MSB - `LCS_IDX_LSB + 1;
    localparam int STAT_CH3_MSB = `LCS_STAT_CH3_LSB + `LCS_CODE_W - 1;

    lcs_pkg::lcs_wr_state_type wr_state_r;
    lcs_pkg::lcs_wr_state_type wr_state_nxt;
    lcs_pkg::lcs_rd_state_type rd_state_r;
    lcs_pkg::lcs_rd_state_type rd_state_nxt;

    logic             aw_held_r;
    logic             aw_held_nxt;
    logic [IDX_W-1:0] aw_idx_r;
    logic [IDX_W-1:0] aw_idx_nxt;
    logic             w_held_r;
    logic             w_held_nxt;
    logic [7:0]       w_byte_r;
    logic [7:0]       w_byte_nxt;
    logic             w_lane0_r;
    logic             w_lane0_nxt;
    logic [1:0]       bresp_r;
    logic [1:0]       bresp_nxt;

    logic [31:0]      rdata_r;
    logic [31:0]      rdata_nxt;
    logic [1:0]       rresp_r;
    logic [1:0]       rresp_nxt;

    logic             aw_take;
    logic             w_take;
    logic             ar_take;
    logic             do_write;
    logic             wr_hit;
    logic [`LCS_NUM_REGS-1:0] wr_sel;
    logic [IDX_W-1:0] ar_idx;
    logic [7:0]       reg_q [`LCS_NUM_REGS];

    lcs_byte_if reg_if [`LCS_NUM_REGS] ();

    // ****************************************************************
    // Handshakes
    // ****************************************************************
    // Readies drop while ce is low so nothing is taken in a frozen cycle
    assign s_axi_awready = ce && (wr_state_r == lcs_pkg::LCS_WR_IDLE) && !aw_held_r;
    assign s_axi_wready  = ce && (wr_state_r == lcs_pkg::LCS_WR_IDLE) && !w_held_r;
    assign s_axi_arready = ce && (rd_state_r == lcs_pkg::LCS_RD_IDLE);

    assign aw_take  = s_axi_awvalid && s_axi_awready;
    assign w_take   = s_axi_wvalid && s_axi_wready;
    assign ar_take  = s_axi_arvalid && s_axi_arready;
    assign do_write = ce && (wr_state_r == lcs_pkg::LCS_WR_IDLE) && aw_held_r && w_held_r;

    // Valids drop with ce too, or a frozen slave would miss a taken answer;
    // Limitation: ce must stay high while an answer waits for valid to stand
    assign s_axi_bvalid = ce && (wr_state_r == lcs_pkg::LCS_WR_RESP);
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = ce && (rd_state_r == lcs_pkg::LCS_RD_DATA);
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    assign ar_idx = s_axi_araddr[`LCS_IDX_MSB:`LCS_IDX_LSB];

    // ****************************************************************
    // Write address decode
    // ****************************************************************
    always_comb begin
        wr_sel = '0;
        wr_hit = 1'b1;
        case (aw_idx_r)
            `LCS_IDX_CH2_HIGH: begin
                wr_sel[`LCS_SEL_CH2_HIGH] = 1'b1;
            end
            `LCS_IDX_CH2_LOW: begin
                wr_sel[`LCS_SEL_CH2_LOW] = 1'b1;
            end
            `LCS_IDX_CH3_HIGH: begin
                wr_sel[`LCS_SEL_CH3_HIGH] = 1'b1;
            end
            `LCS_IDX_CH3_LOW: begin
                wr_sel[`LCS_SEL_CH3_LOW] = 1'b1;
            end
            `LCS_IDX_STATUS: begin
                // Read-only word: write is accepted and dropped
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Setpoint byte registers
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `LCS_NUM_REGS; g++) begin : g_reg
            // Lane 0 strobe gates the byte; other lanes carry nothing
            assign reg_if[g].we    = do_write && wr_sel[g] && w_lane0_r;
            assign reg_if[g].wdata = w_byte_r;
            assign reg_q[g]        = reg_if[g].q;

            lcs_byte_reg u_byte (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .bus     (reg_if[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Setpoint forming per channel
    // ****************************************************************
    lcs_code_join u_ch2 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .high         (reg_if[`LCS_SEL_CH2_HIGH]),
        .low          (reg_if[`LCS_SEL_CH2_LOW]),
        .code         (ch2_current_code),
        .request      (ch2_current_request),
        .nominal_10ua (ch2_current_nominal_10ua)
    );

    lcs_code_join u_ch3 (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .high         (reg_if[`LCS_SEL_CH3_HIGH]),
        .low          (reg_if[`LCS_SEL_CH3_LOW]),
        .code         (ch3_current_code),
        .request      (ch3_current_request),
        .nominal_10ua (ch3_current_nominal_10ua)
    );

    // ****************************************************************
    // Write channel
    // ****************************************************************
    // Address and data are latched apart, so either may come first
    always_comb begin
        wr_state_nxt = wr_state_r;
        aw_held_nxt  = aw_held_r;
        aw_idx_nxt   = aw_idx_r;
        w_held_nxt   = w_held_r;
        w_byte_nxt   = w_byte_r;
        w_lane0_nxt  = w_lane0_r;
        bresp_nxt    = bresp_r;
        if (aw_take) begin
            aw_held_nxt = 1'b1;
            aw_idx_nxt  = s_axi_awaddr[`LCS_IDX_MSB:`LCS_IDX_LSB];
        end
        if (w_take) begin
            w_held_nxt  = 1'b1;
            w_byte_nxt  = s_axi_wdata[7:0];
            w_lane0_nxt = s_axi_wstrb[0];
        end
        case (wr_state_r)
            lcs_pkg::LCS_WR_IDLE: begin
                if (do_write) begin
                    aw_held_nxt  = 1'b0;
                    w_held_nxt   = 1'b0;
                    bresp_nxt    = wr_hit ? `LCS_RESP_OKAY : `LCS_RESP_SLVERR;
                    wr_state_nxt = lcs_pkg::LCS_WR_RESP;
                end
            end
            lcs_pkg::LCS_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_nxt = lcs_pkg::LCS_WR_IDLE;
                end
            end
            default: begin
                wr_state_nxt = lcs_pkg::LCS_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= lcs_pkg::LCS_WR_IDLE;
            aw_held_r  <= 1'b0;
            aw_idx_r   <= '0;
            w_held_r   <= 1'b0;
            w_byte_r   <= `LCS_BYTE_RST;
            w_lane0_r  <= 1'b0;
            bresp_r    <= `LCS_RESP_OKAY;
        end else if (ce) begin
            wr_state_r <= wr_state_nxt;
            aw_held_r  <= aw_held_nxt;
            aw_idx_r   <= aw_idx_nxt;
            w_held_r   <= w_held_nxt;
            w_byte_r   <= w_byte_nxt;
            w_lane0_r  <= w_lane0_nxt;
            bresp_r    <= bresp_nxt;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    always_comb begin
        rd_state_nxt = rd_state_r;
        rdata_nxt    = rdata_r;
        rresp_nxt    = rresp_r;
        case (rd_state_r)
            lcs_pkg::LCS_RD_IDLE: begin
                if (ar_take) begin
                    rdata_nxt    = `LCS_WORD_RST;
                    rresp_nxt    = `LCS_RESP_OKAY;
                    rd_state_nxt = lcs_pkg::LCS_RD_DATA;
                    case (ar_idx)
                        `LCS_IDX_CH2_HIGH: begin
                            rdata_nxt[7:0] = reg_q[`LCS_SEL_CH2_HIGH];
                        end
                        `LCS_IDX_CH2_LOW: begin
                            rdata_nxt[7:0] = reg_q[`LCS_SEL_CH2_LOW];
                        end
                        `LCS_IDX_CH3_HIGH: begin
                            rdata_nxt[7:0] = reg_q[`LCS_SEL_CH3_HIGH];
                        end
                        `LCS_IDX_CH3_LOW: begin
                            rdata_nxt[7:0] = reg_q[`LCS_SEL_CH3_LOW];
                        end
                        `LCS_IDX_STATUS: begin
                            // Shows the setpoints actually driven out
                            // Lags a write by one more cycle than the bytes
                            rdata_nxt[`LCS_CODE_W-1:0] = ch2_current_code;
                            rdata_nxt[STAT_CH3_MSB:`LCS_STAT_CH3_LSB] = ch3_current_code;
                        end
                        default: begin
                            rresp_nxt = `LCS_RESP_SLVERR;
                        end
                    endcase
                end
            end
            lcs_pkg::LCS_RD_DATA: begin
                if (s_axi_rready) begin
                    rd_state_nxt = lcs_pkg::LCS_RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = lcs_pkg::LCS_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= lcs_pkg::LCS_RD_IDLE;
            rdata_r    <= `LCS_WORD_RST;
            rresp_r    <= `LCS_RESP_OKAY;
        end else if (ce) begin
            rd_state_r <= rd_state_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
        end
    end

endmodule : lcs_setpoint_regs

/* lcs_setpoint_regs_asserts.sv */
`timescale 1ns/100ps
`include "lcs_defines.svh"

module lcs_setpoint_regs_asserts (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   ce,
    input wire logic [`LCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic [31:0]            s_axi_wdata,
    input wire logic [3:0]             s_axi_wstrb,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic [`LCS_CODE_W-1:0] ch2_current_code,
    input wire logic                   ch2_current_request,
    input wire logic [`LCS_NOM_W-1:0]  ch2_current_nominal_10ua,
    input wire logic [`LCS_CODE_W-1:0] ch3_current_code,
    input wire logic                   ch3_current_request,
    input wire logic [`LCS_NOM_W-1:0]  ch3_current_nominal_10ua
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Write taken on both channels at once, then two running edges to reach the outputs
    sequence s_wr(logic [7:0] a);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
        s_axi_awaddr == a && s_axi_wstrb[0] ##1 ce [*2];
    endsequence

    chk_ch2_high_code: assert property (
        s_wr(8'h14) |=> ch2_current_code[9:8] == $past(s_axi_wdata[1:0], 3))
        else $error("channel 2 upper code bits wrong");
    chk_ch2_low_code: assert property (
        s_wr(8'h18) |=> ch2_current_code[7:0] == $past(s_axi_wdata[7:0], 3))
        else $error("channel 2 lower code bits wrong");
    chk_ch3_high_code: assert property (
        s_wr(8'h1c) |=> ch3_current_code[9:8] == $past(s_axi_wdata[1:0], 3))
        else $error("channel 3 upper code bits wrong");
    chk_ch3_low_code: assert property (
        s_wr(8'h20) |=> ch3_current_code[7:0] == $past(s_axi_wdata[7:0], 3))
        else $error("channel 3 lower code bits wrong");
    // Past enable guards against a frozen update; nominal value is registered in the same cycle as the code
    chk_ch2_linear: assert property (
        $stable(ch2_current_code) && $past(ce) |->
        ch2_current_nominal_10ua == 18'(ch2_current_code) * `LCS_STEP_10UA &&
        ch2_current_request == (ch2_current_code != 10'h000))
        else $error("channel 2 nominal current wrong");
    chk_ch3_linear: assert property (
        $stable(ch3_current_code) && $past(ce) |->
        ch3_current_nominal_10ua == 18'(ch3_current_code) * `LCS_STEP_10UA &&
        ch3_current_request == (ch3_current_code != 10'h000))
        else $error("channel 3 nominal current wrong");
    chk_reset_zero: assert property (
        $rose(aresetn) |-> ch2_current_code == 10'h000 && ch3_current_code == 10'h000 &&
        !ch2_current_request && !ch3_current_request)
        else $error("setpoints not zero after reset");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready ##1 ce |-> s_axi_rvalid)
        else $error("read answer late");
endmodule : lcs_setpoint_regs_asserts

bind lcs_setpoint_regs lcs_setpoint_regs_asserts i_chk (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .ch2_current_code, .ch2_current_request, .ch2_current_nominal_10ua,
    .ch3_current_code, .ch3_current_request, .ch3_current_nominal_10ua);

/* lcs_setpoint_regs_test.sv */
`timescale 1ns/100ps
`include "lcs_defines.svh"

module lcs_setpoint_regs_test;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  ch2_current_code, ch3_current_code;
    logic        ch2_current_request, ch3_current_request;
    logic [17:0] ch2_current_nominal_10ua, ch3_current_nominal_10ua;
    int          failures = 0, num_checks = 0, seed = 74;
    logic        stress = 1'b0;
    logic [7:0]  regs [4];
    logic [7:0]  addrs [4] = '{8'h14, 8'h18, 8'h1c, 8'h20};

    always #2 aclk = ~aclk;

    // Clock enable drops at random once stress is on
    always @(posedge aclk) ce <= !stress || ($random(seed) % 4 != 0);

    lcs_setpoint_regs i_dut (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ch2_current_code, .ch2_current_request, .ch2_current_nominal_10ua,
        .ch3_current_code, .ch3_current_request, .ch3_current_nominal_10ua);

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task timed_out;
        failures++;
        $display("wrong value at %0t: handshake timeout", $time);
        end_of_test();
    endtask : timed_out

    task check_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : check_data

    task check_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: response %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    // Expected request and nominal current follow from the code alone
    task check_out(input logic [9:0] c, input logic r, input logic [17:0] n,
                   input logic [9:0] e);
        num_checks++;
        if ({c, r, n} !== {e, e != 10'h000, 18'(e) * `LCS_STEP_10UA}) begin
            failures++;
            $display("wrong value at %0t: setpoint %h expected %h", $time, c, e);
        end
    endtask : check_out

    function automatic logic [9:0] f_code(input logic [7:0] h, input logic [7:0] l);
        return {h[1:0], l};
    endfunction : f_code

    // ****************************************************************
    // Bus master
    // ****************************************************************
    task axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st,
                   input logic [1:0] er);
        int   n;
        logic aw;
        logic w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        for (n = 0; aw || w; n++) begin
            if (n > 50) timed_out();
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        n = 0;
        do begin
            if (n++ > 50) timed_out();
            @(posedge aclk);
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check_resp(s_axi_bresp, er);
    endtask : axi_write

    task read_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            if (n++ > 50) timed_out();
            @(posedge aclk);
        end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        n = 0;
        do begin
            if (n++ > 50) timed_out();
            @(posedge aclk);
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check_data(s_axi_rdata, ed);
        check_resp(s_axi_rresp, er);
    endtask : read_chk

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [9:0] c2;
        logic [9:0] c3;
        int         i;
        int         j;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (j = 0; j < 4; j++) read_chk(addrs[j], 32'h00000000, `LCS_RESP_OKAY);
        check_out(ch2_current_code, ch2_current_request, ch2_current_nominal_10ua, 10'h000);
        check_out(ch3_current_code, ch3_current_request, ch3_current_nominal_10ua, 10'h000);
        // Corners first: all ones, spare bits set with zero code, carry across the byte
        for (i = 0; i < 24; i++) begin
            stress = (i >= 12);
            for (j = 0; j < 4; j++) regs[j] = 8'($random(seed));
            if (i == 0) regs = '{8'hff, 8'hff, 8'hff, 8'hff};
            if (i == 1) regs = '{8'hfc, 8'h00, 8'hfc, 8'h00};
            if (i == 2) regs = '{8'h01, 8'h00, 8'h00, 8'hff};
            for (j = 0; j < 4; j++) axi_write(addrs[j], regs[j], 4'hf, `LCS_RESP_OKAY);
            for (j = 0; j < 4; j++) read_chk(addrs[j], {24'h0, regs[j]}, `LCS_RESP_OKAY);
            c2 = f_code(regs[0], regs[1]);
            c3 = f_code(regs[2], regs[3]);
            read_chk(8'h40, {6'h00, c3, 6'h00, c2}, `LCS_RESP_OKAY);
            check_out(ch2_current_code, ch2_current_request, ch2_current_nominal_10ua, c2);
            check_out(ch3_current_code, ch3_current_request, ch3_current_nominal_10ua, c3);
        end
        // Byte lane zero disabled, so the low byte must keep its value
        axi_write(8'h18, 8'h5a, 4'he, `LCS_RESP_OKAY);
        read_chk(8'h18, {24'h0, regs[1]}, `LCS_RESP_OKAY);
        axi_write(8'h24, 8'h33, 4'hf, `LCS_RESP_SLVERR);
        read_chk(8'h24, 32'h00000000, `LCS_RESP_SLVERR);
        axi_write(8'h40, 8'h77, 4'hf, `LCS_RESP_OKAY);
        read_chk(8'h40, {6'h00, c3, 6'h00, c2}, `LCS_RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (j = 0; j < 4; j++) read_chk(addrs[j], 32'h00000000, `LCS_RESP_OKAY);
        check_out(ch2_current_code, ch2_current_request, ch2_current_nominal_10ua, 10'h000);
        check_out(ch3_current_code, ch3_current_request, ch3_current_nominal_10ua, 10'h000);
        end_of_test();
    end
endmodule : lcs_setpoint_regs_test
